// [rtl/bitop_pkg.sv]
// Constants and types of the bit, flag, shift and load/store executor
package bitop_pkg;
    // Register byte offsets
    localparam logic [7:0] CMD_OFS      = 8'h00;
    localparam logic [7:0] OPERAND_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] PC_OFS       = 8'h0C;
    localparam logic [7:0] GPR_SEL_OFS  = 8'h10;
    localparam logic [7:0] GPR_DATA_OFS = 8'h14;
    // Command word fields
    localparam int OP_LSB   = 0;
    localparam int RD_LSB   = 8;
    localparam int BIT_LSB  = 16;
    localparam int PTR_LSB  = 20;
    localparam int MODE_LSB = 22;
    // Status word fields
    localparam int BUSY_BIT  = 8;
    localparam int TAKEN_BIT = 9;
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // Dedicated flag opcodes: bit 5 marks them, bit 3 means clear
    localparam int DED_BIT = 5;
    localparam int DED_CLR = 3;
    // Reset values
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [4:0]  SEL_RST   = 5'h00;
    // I/O registers sit at this data-space base
    localparam logic [15:0] IO_BASE   = 16'h0020;
    // First register of the X pair; pointer n uses 24 + 2n
    localparam logic [4:0]  PTR_BASE  = 5'h18;
    typedef enum logic [1:0] {
        MODE_PLAIN = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_PRE_DEC = 2'h2,
        MODE_DISP = 2'h3
    } mode_type;
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_BRANCH_NO_OVERFLOW = 6'h01,
        OP_BRANCH_IRQ_ON = 6'h02,
        OP_BRANCH_IRQ_OFF = 6'h03,
        OP_IO_BIT_SET = 6'h04,
        OP_IO_BIT_CLEAR = 6'h05,
        OP_SHIFT_LEFT_LOGICAL = 6'h06,
        OP_SHIFT_RIGHT_LOGICAL = 6'h07,
        OP_ROTATE_LEFT_CARRY = 6'h08,
        OP_ROTATE_RIGHT_CARRY = 6'h09,
        OP_SHIFT_RIGHT_ARITH = 6'h0A,
        OP_REG_BIT_TO_TFLAG = 6'h0B,
        OP_TFLAG_TO_REG_BIT = 6'h0C,
        OP_FLAG_SET_INDEXED = 6'h0D,
        OP_FLAG_CLEAR_INDEXED = 6'h0E,
        OP_POINTER_LOAD = 6'h0F,
        OP_DIRECT_LOAD = 6'h10,
        OP_POINTER_STORE = 6'h11
    } op_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EX1  = 2'b01,
        ST_EX2  = 2'b11
    } state_type;
endpackage

// [rtl/bitop_exec.sv]
// Executor for branches, bit, flag, shift and pointer load/store ops
// Function
// - Branch on overflow clear: PC+k+1, 1/2 cycles
// - Branch when interrupts on: PC+k+1, 1/2 cycles
// - Branch when interrupts off: PC+k+1, 1/2 cycles
// - I/O bit set/clear, flags kept, two cycles
// - Left shift/rotate one cycle, Z C N V
// - Right shift/rotate/arith one cycle, Z C N V
// - Register bit copied into T only
// - T copied into register bit, flags kept
// - Dedicated and indexed single flag set/clear
// - Load at pointer, then pointer plus one
// - Pointer minus one, then load at it
// - Load at Y/Z plus displacement, pointer kept
// - Direct load from address constant, two cycles
// - Store at pointer, then pointer plus one
// - Pointer minus one, then store at it
`timescale 1ns/10ps
module bitop_exec (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    input  wire logic [7:0]  mem_rdata
);
    import bitop_pkg::*;

    logic [7:0]  gpr [32];
    logic [7:0]  flags_r;
    logic [15:0] pc_r;
    logic [31:0] cmd_r;
    logic [15:0] operand_r;
    logic [4:0]  gpr_sel_r;
    logic        taken_r;
    state_type   state_r;
    logic        wr_phase_r;
    logic [7:0]  wr_addr_r;
    logic [15:0] ptr_nxt_r;

    logic        bus_addr_ok;
    logic        start;
    op_type      s_op;
    mode_type    s_mode;
    logic [15:0] s_ptr;
    logic [15:0] s_eff;
    logic [4:0]  s_lo;
    op_type      op;
    mode_type    mode;
    logic [4:0]  rd;
    logic [2:0]  bsel;
    logic [4:0]  p_lo;
    logic [4:0]  p_hi;
    logic [7:0]  rv;
    logic [7:0]  sh_res;
    logic        sh_c;
    logic        br_cond;
    logic [15:0] br_target;
    logic        ptr_upd;
    logic [7:0]  mask;

    // Bus side: zero wait state slave, only word registers decoded
    assign bus_addr_ok = (haddr[31:8] == 24'h000000);
    // A command written while busy is dropped, never queued
    assign start = wr_phase_r && (wr_addr_r == CMD_OFS) && (state_r == ST_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_phase_r <= hsel && htrans[1] && hready && hwrite && bus_addr_ok;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            if (hsel && htrans[1] && hready && !hwrite && bus_addr_ok) begin
                unique case (haddr[7:0])
                    CMD_OFS:      hrdata <= cmd_r;
                    OPERAND_OFS:  hrdata <= {16'h0000, operand_r};
                    STATUS_OFS:   hrdata <= {22'h000000, taken_r,
                                             state_r != ST_IDLE, flags_r};
                    PC_OFS:       hrdata <= {16'h0000, pc_r};
                    GPR_SEL_OFS:  hrdata <= {27'h0000000, gpr_sel_r};
                    GPR_DATA_OFS: hrdata <= {24'h000000, gpr[gpr_sel_r]};
                    default:      hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand_r <= 16'h0000;
            gpr_sel_r <= SEL_RST;
        end else if (wr_phase_r) begin
            if (wr_addr_r == OPERAND_OFS) begin
                operand_r <= hwdata[15:0];
            end
            if (wr_addr_r == GPR_SEL_OFS) begin
                gpr_sel_r <= hwdata[4:0];
            end
        end
    end

    // Start-time address: pointers read straight from the pair
    assign s_op = op_type'(hwdata[OP_LSB +: 6]);
    assign s_mode = mode_type'(hwdata[MODE_LSB +: 2]);
    assign s_lo = PTR_BASE + {2'b00, hwdata[PTR_LSB +: 2], 1'b0};
    assign s_ptr = {gpr[s_lo + 5'h01], gpr[s_lo]};

    always_comb begin
        unique case (s_mode)
            MODE_PLAIN:    s_eff = s_ptr;
            MODE_POST_INC: s_eff = s_ptr;
            MODE_PRE_DEC:  s_eff = s_ptr - 16'h0001;
            MODE_DISP:     s_eff = s_ptr + {10'h000, operand_r[5:0]};
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r <= 32'h00000000;
            ptr_nxt_r <= 16'h0000;
        end else if (start) begin
            cmd_r <= hwdata;
            // Pre-decrement keeps the lowered value; post-increment adds one
            if (s_mode == MODE_POST_INC) begin
                ptr_nxt_r <= s_ptr + 16'h0001;
            end else begin
                ptr_nxt_r <= s_eff;
            end
        end
    end

    // Sequencer: EX1 for every op, EX2 for memory ops and taken branches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_EX1;
                    end
                end
                ST_EX1: begin
                    if (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR
                        || op == OP_POINTER_LOAD || op == OP_DIRECT_LOAD
                        || op == OP_POINTER_STORE || br_cond) begin
                        state_r <= ST_EX2;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_EX2: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign op = op_type'(cmd_r[OP_LSB +: 6]);
    assign mode = mode_type'(cmd_r[MODE_LSB +: 2]);
    assign rd = cmd_r[RD_LSB +: 5];
    assign bsel = cmd_r[BIT_LSB +: 3];
    assign p_lo = PTR_BASE + {2'b00, cmd_r[PTR_LSB +: 2], 1'b0};
    assign p_hi = p_lo + 5'h01;
    assign rv = gpr[rd];
    assign mask = 8'h01 << bsel;
    assign ptr_upd = (op == OP_POINTER_LOAD || op == OP_POINTER_STORE)
                     && (mode == MODE_POST_INC || mode == MODE_PRE_DEC);
    assign br_target = pc_r + {{9{operand_r[6]}}, operand_r[6:0]} + 16'h0001;

    always_comb begin
        br_cond = 1'b0;
        unique case (op)
            OP_BRANCH_NO_OVERFLOW: br_cond = !flags_r[FLAG_V];
            OP_BRANCH_IRQ_ON:      br_cond = flags_r[FLAG_I];
            OP_BRANCH_IRQ_OFF:     br_cond = !flags_r[FLAG_I];
            default:               br_cond = 1'b0;
        endcase
    end

    always_comb begin
        sh_res = rv;
        sh_c = flags_r[FLAG_C];
        unique case (op)
            OP_SHIFT_LEFT_LOGICAL: begin
                sh_res = {rv[6:0], 1'b0};
                sh_c = rv[7];
            end
            OP_ROTATE_LEFT_CARRY: begin
                sh_res = {rv[6:0], flags_r[FLAG_C]};
                sh_c = rv[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                sh_res = {1'b0, rv[7:1]};
                sh_c = rv[0];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                sh_res = {flags_r[FLAG_C], rv[7:1]};
                sh_c = rv[0];
            end
            OP_SHIFT_RIGHT_ARITH: begin
                sh_res = {rv[7], rv[7:1]};
                sh_c = rv[0];
            end
            default: sh_res = rv;
        endcase
    end

    // Program counter: not-taken steps by one, taken adds offset plus one in EX2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_r <= PC_RST;
            taken_r <= 1'b0;
        end else begin
            if (wr_phase_r && wr_addr_r == PC_OFS) begin
                pc_r <= hwdata[15:0];
            end
            if (start) begin
                taken_r <= 1'b0;
            end
            if (state_r == ST_EX1 && !br_cond
                && (op == OP_BRANCH_NO_OVERFLOW || op == OP_BRANCH_IRQ_ON
                    || op == OP_BRANCH_IRQ_OFF)) begin
                pc_r <= pc_r + 16'h0001;
            end
            if (state_r == ST_EX2 && br_cond) begin
                pc_r <= br_target;
                taken_r <= 1'b1;
            end
        end
    end

    // Status flags; branches, loads, stores and I/O ops leave them alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= FLAGS_RST;
        end else begin
            if (wr_phase_r && wr_addr_r == STATUS_OFS) begin
                flags_r <= hwdata[7:0];
            end
            if (state_r == ST_EX1) begin
                if (op[DED_BIT]) begin
                    flags_r[op[2:0]] <= !op[DED_CLR];
                end else begin
                    unique case (op)
                        OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                        OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT_CARRY,
                        OP_SHIFT_RIGHT_ARITH: begin
                            flags_r[FLAG_Z] <= (sh_res == 8'h00);
                            flags_r[FLAG_C] <= sh_c;
                            flags_r[FLAG_N] <= sh_res[7];
                            flags_r[FLAG_V] <= sh_res[7] ^ sh_c;
                        end
                        OP_REG_BIT_TO_TFLAG: flags_r[FLAG_T] <= rv[bsel];
                        OP_FLAG_SET_INDEXED: flags_r[bsel] <= 1'b1;
                        OP_FLAG_CLEAR_INDEXED: flags_r[bsel] <= 1'b0;
                        default: flags_r <= flags_r;
                    endcase
                end
            end
        end
    end

    // Register file: execution writes land after any bus write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= 8'h00;
            end
        end else begin
            if (wr_phase_r && wr_addr_r == GPR_DATA_OFS) begin
                gpr[gpr_sel_r] <= hwdata[7:0];
            end
            if (state_r == ST_EX1 && !op[DED_BIT]) begin
                unique case (op)
                    OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                    OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT_CARRY,
                    OP_SHIFT_RIGHT_ARITH: gpr[rd] <= sh_res;
                    OP_TFLAG_TO_REG_BIT: gpr[rd][bsel] <= flags_r[FLAG_T];
                    default: gpr[rd] <= gpr[rd];
                endcase
                if (ptr_upd) begin
                    gpr[p_lo] <= ptr_nxt_r[7:0];
                    gpr[p_hi] <= ptr_nxt_r[15:8];
                end
            end
            // Pointer as its own load target ends with the loaded byte
            if (state_r == ST_EX2
                && (op == OP_POINTER_LOAD || op == OP_DIRECT_LOAD)) begin
                gpr[rd] <= mem_rdata;
            end
        end
    end

    // Memory port: address and strobes are issued at the start edge, except the I/O write strobe, issued at the end of EX2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            if (start) begin
                unique case (s_op)
                    OP_POINTER_LOAD: begin
                        mem_addr <= s_eff;
                        mem_re <= 1'b1;
                    end
                    OP_DIRECT_LOAD: begin
                        mem_addr <= operand_r;
                        mem_re <= 1'b1;
                    end
                    OP_POINTER_STORE: begin
                        mem_addr <= s_eff;
                        mem_wdata <= gpr[hwdata[RD_LSB +: 5]];
                        mem_we <= 1'b1;
                    end
                    OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                        mem_addr <= IO_BASE + {11'h000, operand_r[4:0]};
                        mem_re <= 1'b1;
                    end
                    default: mem_re <= 1'b0;
                endcase
            end
            // Read-modify-write: only the addressed bit changes
            if (state_r == ST_EX2 && op == OP_IO_BIT_SET) begin
                mem_wdata <= mem_rdata | mask;
                mem_we <= 1'b1;
            end
            if (state_r == ST_EX2 && op == OP_IO_BIT_CLEAR) begin
                mem_wdata <= mem_rdata & ~mask;
                mem_we <= 1'b1;
            end
        end
    end

endmodule

// [tb/data_mem.sv]
// Synchronous data memory model on the far side of the executor
`timescale 1ns/10ps
module data_mem (
    input  wire logic        hclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] q_r = 8'h00;
    logic       vld_r = 1'b0;
    // Inverse outside the read cycle, so stale data never passes
    assign mem_rdata = vld_r ? q_r : ~q_r;
    always @(posedge hclk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_re) q_r <= mem[mem_addr];
        vld_r <= mem_re;
    end
endmodule

// [tb/bitop_exec_props.sv]
// Concurrent checks on the executor ports
`timescale 1ns/10ps
module bitop_exec_props
    import bitop_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    input wire logic        mem_re,
    input wire logic [7:0]  mem_rdata
);
    logic        wr_r;
    logic [7:0]  ofs_r;
    logic [5:0]  op_r;
    logic [2:0]  bit_r;
    logic [15:0] opnd_r;
    logic        cmd_dp;
    logic [5:0]  cop;
    logic [15:0] io_a;
    assign cmd_dp = wr_r && ofs_r == CMD_OFS;
    assign cop = hwdata[5:0];
    assign io_a = IO_BASE + 16'(opnd_r[4:0]);
    // Tracks which op the memory strobes belong to
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            ofs_r <= 8'h00;
            op_r <= 6'h00;
            bit_r <= 3'h0;
            opnd_r <= 16'h0000;
        end else begin
            wr_r <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h000000;
            ofs_r <= haddr[7:0];
            if (cmd_dp) begin
                op_r <= cop;
                bit_r <= hwdata[18:16];
            end
            if (wr_r && ofs_r == OPERAND_OFS) begin
                opnd_r <= hwdata[15:0];
            end
        end
    end
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence cmd_is(logic [5:0] o);
        cmd_dp && cop == o;
    endsequence
    sequence quiet3;
        (!mem_re && !mem_we) [*3];
    endsequence
    chk_io_set_rmw: assert property (mem_re && op_r == OP_IO_BIT_SET |->
        mem_addr == io_a ##2 mem_we && mem_addr == io_a
        && mem_wdata == ($past(mem_rdata) | (8'h01 << bit_r))) else $error("io set write wrong");
    chk_io_clr_rmw: assert property (mem_re && op_r == OP_IO_BIT_CLEAR |->
        mem_addr == io_a ##2 mem_we && mem_addr == io_a
        && mem_wdata == ($past(mem_rdata) & ~(8'h01 << bit_r))) else $error("io clear wrong");
    chk_load_strobe: assert property (cmd_is(OP_POINTER_LOAD) |=>
        mem_re && !mem_we ##1 !mem_re) else $error("pointer load strobe wrong");
    chk_direct_addr: assert property (cmd_is(OP_DIRECT_LOAD) |=>
        mem_re && mem_addr == opnd_r ##1 !mem_re) else $error("direct load address wrong");
    chk_store_strobe: assert property (cmd_is(OP_POINTER_STORE) |=>
        mem_we && !mem_re ##1 !mem_we) else $error("store strobe wrong");
    chk_shift_quiet: assert property (cmd_dp && cop inside {[6'h06:6'h0A]} |=>
        quiet3) else $error("shift touched memory");
    chk_flag_quiet: assert property (cmd_dp && (cop inside {[6'h0B:6'h0E]} || cop[DED_BIT])
        |=> quiet3) else $error("flag op touched memory");
    chk_branch_quiet: assert property (cmd_dp && cop inside {[6'h01:6'h03]} |=>
        quiet3) else $error("branch touched memory");
endmodule
bind bitop_exec bitop_exec_props chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata));

// [tb/testbench.sv]
// Self-checking bench of the bit, flag, shift and load/store executor
`timescale 1ns/10ps
module testbench;
    import bitop_pkg::*;
    typedef struct {
        op_type      op;
        logic [2:0]  b;
        logic [15:0] opnd;
        logic [7:0]  fin, rin, rout, fout;
        logic [15:0] pc;
    } row_type;
    typedef struct {
        op_type      op;
        logic [1:0]  p, m;
        logic [15:0] pv, opnd, ma;
        logic [7:0]  d;
        logic [15:0] pa;
    } mrow_type;
    row_type rows[$] = '{
        '{OP_BRANCH_NO_OVERFLOW, 3'h0, 16'h5, 8'h0, 8'h0, 8'h0, 8'h0, 16'h106},
        '{OP_BRANCH_NO_OVERFLOW, 3'h0, 16'h5, 8'h8, 8'h0, 8'h0, 8'h8, 16'h101},
        '{OP_BRANCH_NO_OVERFLOW, 3'h0, 16'h7D, 8'h0, 8'h0, 8'h0, 8'h0, 16'hFE},
        '{OP_BRANCH_IRQ_ON, 3'h0, 16'h2, 8'h80, 8'h0, 8'h0, 8'h80, 16'h103},
        '{OP_BRANCH_IRQ_ON, 3'h0, 16'h2, 8'h7F, 8'h0, 8'h0, 8'h7F, 16'h101},
        '{OP_BRANCH_IRQ_OFF, 3'h0, 16'h10, 8'h7F, 8'h0, 8'h0, 8'h7F, 16'h111},
        '{OP_BRANCH_IRQ_OFF, 3'h0, 16'h10, 8'h80, 8'h0, 8'h0, 8'h80, 16'h101},
        '{OP_SHIFT_LEFT_LOGICAL, 3'h0, 16'h0, 8'h31, 8'h81, 8'h02, 8'h39, 16'h0},
        '{OP_ROTATE_LEFT_CARRY, 3'h0, 16'h0, 8'h31, 8'h81, 8'h03, 8'h39, 16'h0},
        '{OP_ROTATE_LEFT_CARRY, 3'h0, 16'h0, 8'h30, 8'h7F, 8'hFE, 8'h3C, 16'h0},
        '{OP_SHIFT_RIGHT_LOGICAL, 3'h0, 16'h0, 8'h31, 8'h81, 8'h40, 8'h39, 16'h0},
        '{OP_SHIFT_RIGHT_LOGICAL, 3'h0, 16'h0, 8'h0, 8'h01, 8'h00, 8'h0B, 16'h0},
        '{OP_ROTATE_RIGHT_CARRY, 3'h0, 16'h0, 8'h31, 8'h81, 8'hC0, 8'h35, 16'h0},
        '{OP_SHIFT_RIGHT_ARITH, 3'h0, 16'h0, 8'h31, 8'h81, 8'hC0, 8'h35, 16'h0},
        '{OP_REG_BIT_TO_TFLAG, 3'h3, 16'h0, 8'h0, 8'h08, 8'h08, 8'h40, 16'h0},
        '{OP_TFLAG_TO_REG_BIT, 3'h5, 16'h0, 8'h40, 8'h00, 8'h20, 8'h40, 16'h0},
        '{OP_TFLAG_TO_REG_BIT, 3'h0, 16'h0, 8'hBF, 8'hFF, 8'hFE, 8'hBF, 16'h0}};
    mrow_type mrows[$] = '{
        '{OP_POINTER_LOAD, 2'h1, 2'h1, 16'h00FF, 16'h0, 16'h00FF, 8'h5A, 16'h0100},
        '{OP_POINTER_LOAD, 2'h2, 2'h2, 16'h0200, 16'h0, 16'h01FF, 8'hA5, 16'h01FF},
        '{OP_POINTER_LOAD, 2'h3, 2'h3, 16'h0300, 16'h3F, 16'h033F, 8'h3C, 16'h0300},
        '{OP_POINTER_LOAD, 2'h2, 2'h3, 16'h0410, 16'h1, 16'h0411, 8'h96, 16'h0410},
        '{OP_DIRECT_LOAD, 2'h3, 2'h0, 16'h0000, 16'h1234, 16'h1234, 8'hC3, 16'h0000},
        '{OP_POINTER_STORE, 2'h3, 2'h1, 16'h04FF, 16'h0, 16'h04FF, 8'h77, 16'h0500},
        '{OP_POINTER_STORE, 2'h1, 2'h2, 16'h0600, 16'h0, 16'h05FF, 8'h88, 16'h05FF}};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rv;
    logic        hready, hresp, mem_we, mem_re;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata, fl;
    logic [4:0]  pr;
    mrow_type    mr;
    int          errors = 0;
    int          n_checks = 0;
    always #2 hclk = ~hclk;
    bitop_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    data_mem mem_u (.hclk(hclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read data is taken at the edge ending the data phase
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rv = hrdata;
    endtask
    task automatic setr(logic [4:0] i, logic [7:0] v);
        xfer(1'b1, GPR_SEL_OFS, 32'(i));
        xfer(1'b1, GPR_DATA_OFS, 32'(v));
    endtask
    task automatic getr(logic [4:0] i);
        xfer(1'b1, GPR_SEL_OFS, 32'(i));
        xfer(1'b0, GPR_DATA_OFS, 32'h0);
    endtask
    // Busy drops commands: poll till idle
    task automatic exec(logic [31:0] c);
        xfer(1'b1, CMD_OFS, c);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, STATUS_OFS, 32'h0);
            if (rv[BUSY_BIT] === 1'b0) break;
        end
        chk("busy", 32'h0, 32'(rv[BUSY_BIT]));
        repeat (2) @(posedge hclk);
    endtask
    function automatic logic [31:0] mk(logic [5:0] o, logic [4:0] r, logic [2:0] b,
                                       logic [1:0] p, logic [1:0] m);
        return {8'h00, m, p, 1'b0, b, 3'h0, r, 2'h0, o};
    endfunction
    initial begin
        #80000;
        errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk("status reset", 32'h0, rv);
        xfer(1'b0, PC_OFS, 32'h0);
        chk("pc reset", 32'h0, rv);
        getr(5'h1F);
        chk("gpr reset", 32'h0, rv);
        xfer(1'b1, 8'h40, 32'hFFFFFFFF);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rv);
        chk("hresp", 32'h0, 32'(hresp));
        foreach (rows[i]) begin
            xfer(1'b1, STATUS_OFS, 32'(rows[i].fin));
            xfer(1'b1, PC_OFS, 32'h100);
            xfer(1'b1, OPERAND_OFS, 32'(rows[i].opnd));
            setr(5'h10, rows[i].rin);
            exec(mk(rows[i].op, 5'h10, rows[i].b, 2'h0, 2'h0));
            getr(5'h10);
            chk("reg", 32'(rows[i].rout), rv);
            xfer(1'b0, STATUS_OFS, 32'h0);
            chk("flags", 32'({rows[i].op < OP_IO_BIT_SET && rows[i].pc != 16'h101, 1'b0,
                rows[i].fout}), 32'(rv[9:0]));
            xfer(1'b0, PC_OFS, 32'h0);
            if (rows[i].op < OP_IO_BIT_SET) chk("pc", 32'(rows[i].pc), 32'(rv[15:0]));
        end
        for (int f = 0; f < 8; f++) begin
            for (int k = 0; k < 4; k++) begin
                fl = k[0] ? 8'hFF : 8'h00;
                xfer(1'b1, STATUS_OFS, 32'(fl));
                exec(k < 2 ? 32'(32 + 8 * k + f) : mk(k == 2 ? OP_FLAG_SET_INDEXED :
                     OP_FLAG_CLEAR_INDEXED, 5'h0, 3'(f), 2'h0, 2'h0));
                xfer(1'b0, STATUS_OFS, 32'h0);
                chk("flag op", 32'(fl ^ (8'h01 << f)), 32'(rv[7:0]));
            end
        end
        foreach (mrows[i]) begin
            mr = mrows[i];
            pr = 5'(24 + 2 * mr.p);
            mem_u.mem[mr.ma] = (mr.op == OP_POINTER_STORE) ? 8'h00 : mr.d;
            setr(pr, mr.pv[7:0]);
            setr(pr + 5'h1, mr.pv[15:8]);
            setr(5'h10, (mr.op == OP_POINTER_STORE) ? mr.d : 8'h00);
            xfer(1'b1, OPERAND_OFS, 32'(mr.opnd));
            xfer(1'b1, STATUS_OFS, 32'h55);
            exec(mk(mr.op, 5'h10, 3'h0, mr.p, mr.m));
            getr(5'h10);
            chk("data reg", 32'(mr.d), rv);
            chk("data mem", 32'(mr.d), 32'(mem_u.mem[mr.ma]));
            getr(pr);
            chk("ptr low", 32'(mr.pa[7:0]), rv);
            getr(pr + 5'h1);
            chk("ptr high", 32'(mr.pa[15:8]), rv);
            xfer(1'b0, STATUS_OFS, 32'h0);
            chk("mem flags", 32'h55, 32'(rv[7:0]));
        end
        mem_u.mem[16'h003F] = 8'h00;
        xfer(1'b1, OPERAND_OFS, 32'h1F);
        xfer(1'b1, STATUS_OFS, 32'hA3);
        exec(mk(OP_IO_BIT_SET, 5'h0, 3'h3, 2'h0, 2'h0));
        chk("io set", 32'h08, 32'(mem_u.mem[16'h003F]));
        mem_u.mem[16'h003F] = 8'hFF;
        exec(mk(OP_IO_BIT_CLEAR, 5'h0, 3'h7, 2'h0, 2'h0));
        chk("io clear", 32'h7F, 32'(mem_u.mem[16'h003F]));
        xfer(1'b0, STATUS_OFS, 32'h0);
        chk("io flags", 32'hA3, 32'(rv[7:0]));
        xfer(1'b1, PC_OFS, 32'h1234);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, PC_OFS, 32'h0);
        chk("pc after reset", 32'h0, rv);
        summarize();
    end
endmodule
